// >>> logic/wws_pkg.sv
// Constants and types shared by the windowed watchdog reset supervisor
// Contract
// - At power-up reset is held low, and after the monitor input rises it stays low for one more watchdog period.
// - Reset goes low whenever the monitor input falls below threshold, with dips under about 5 us filtered out.
// - All intervals come from one timebase, and the watchdog reset pulse is one fortieth of the period.
// - A closed window starts right after each timer restart and lasts the period minus 20 percent of it.
// - The open window follows the closed one, lasts twice the 20 percent fraction and ends at period plus fraction.
// - With a 100 ms period a service is accepted only from 80 ms to 120 ms after the last restart.
// - A clear pulse in the open window restarts the timer without asserting reset.
// - A clear pulse in the closed window asserts reset and starts a new timeout sequence.
// - Without service, reset pulses low for one pulse width after each closed plus open window, repeatedly.
// - Clear pulses are ignored until the power-on delay has finished.
package wws_pkg;

  // ----------------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 25;
  localparam int CLK_HZ             = 40_000_000;
  localparam int WATCHDOG_PERIOD_MS = 100;
  localparam int UNITS_PER_PERIOD   = 40;
  localparam int OPEN_FRACTION_PCT  = 20;
  // One pulse unit = period / 40 = 2.5 ms
  localparam int UNIT_CYC = (CLK_HZ / 1000) * WATCHDOG_PERIOD_MS
                            / UNITS_PER_PERIOD;
  localparam int PRE_W    = 17;

  // ----------------------------------------------------------------------
  // Window lengths in pulse units
  // ----------------------------------------------------------------------
  localparam int UNIT_W = 6;
  localparam logic [UNIT_W-1:0] POR_UNITS   = 6'(UNITS_PER_PERIOD);
  localparam logic [UNIT_W-1:0] CLOSED_UNITS =
    6'(UNITS_PER_PERIOD - UNITS_PER_PERIOD * OPEN_FRACTION_PCT / 100);
  localparam logic [UNIT_W-1:0] OPEN_UNITS =
    6'(2 * UNITS_PER_PERIOD * OPEN_FRACTION_PCT / 100);
  localparam logic [UNIT_W-1:0] PULSE_UNITS = 6'h01;

  // ----------------------------------------------------------------------
  // Monitor input filter
  // ----------------------------------------------------------------------
  localparam int FILT_NS  = 5000;
  localparam int FILT_W   = 8;
  localparam logic [FILT_W-1:0] FILT_CYC = 8'(FILT_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    WWS_POR,
    WWS_CLOSED,
    WWS_OPEN,
    WWS_PULSE
  } wws_state_t;

endpackage

// >>> logic/wws_vin_filter.sv
// Glitch filter on the monitor comparator output
`timescale 1ns/100ps
module wws_vin_filter
  import wws_pkg::*;
(
  input  wire logic clk_i,     // 40 MHz clock
  input  wire logic arst_n_i,  // Async reset, active low
  input  wire logic ce_i,      // Clock enable
  input  wire logic above_i,   // Comparator: input above threshold
  output logic      ok_o       // Filtered level
);

  typedef struct packed {
    logic [FILT_W-1:0] cnt;
    logic              ok;
  } wws_filt_t;

  wws_filt_t r;
  wws_filt_t next_r;

  // Only a drop is filtered; a rise passes at once since the power-on
  // delay that follows already rejects chatter.
  always_comb
  begin
    next_r = r;
    if (above_i)
    begin
      next_r.cnt = '0;
      next_r.ok  = 1'b1;
    end
    else if (r.cnt >= FILT_CYC - 8'h01)
    begin
      next_r.ok = 1'b0;
    end
    else
    begin
      next_r.cnt = r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      r <= '{cnt: 8'h00, ok: 1'b0};
    end
    else if (ce_i)
    begin
      r <= next_r;
    end
  end

  assign ok_o = r.ok;

endmodule // wws_vin_filter

// >>> logic/wws_supervisor.sv
// Windowed watchdog and voltage supervisor driving the system reset
`timescale 1ns/100ps
module wws_supervisor
  import wws_pkg::*;
#(
  parameter int UNIT_CYC_P = wws_pkg::UNIT_CYC  // Cycles per pulse unit
)
(
  input  wire logic clk_i,          // 40 MHz clock
  input  wire logic arst_n_i,       // Async reset, active low
  input  wire logic ce_i,           // Clock enable, freezes state low
  input  wire logic vin_above_i,    // Comparator: monitor above threshold
  input  wire logic wd_clear_n_i,   // Watchdog clear, falling edge acts
  output logic      sys_reset_n_o,  // Open-drain data, always low
  output logic      sys_reset_oe_o  // High while reset is driven low
);

  import wws_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    wws_state_t        state;
    logic [PRE_W-1:0]  pre;
    logic [UNIT_W-1:0] units;
    logic              clr_q;
    logic              drive;
    logic              pin;
  } wws_regs_t;

  wws_regs_t r;
  wws_regs_t next_r;
  logic      vin_ok;
  logic      tick;
  logic      clr_edge;

  wws_vin_filter u_filt (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .above_i  (vin_above_i),
    .ok_o     (vin_ok)
  );

  // ----------------------------------------------------------------------
  // Timebase and edge detect
  // ----------------------------------------------------------------------
  // One prescaler feeds every sequencer interval so the ratios hold exactly; the monitor filter counts raw clock cycles
  assign tick     = (r.pre == PRE_W'(UNIT_CYC_P - 1));
  assign clr_edge = r.clr_q & ~wd_clear_n_i;

  function automatic logic done(input logic [UNIT_W-1:0] units,
                                input logic [UNIT_W-1:0] len,
                                input logic              tk);
    done = tk && (units == len - 6'h01);
  endfunction

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_r       = r;
    next_r.clr_q = wd_clear_n_i;
    next_r.pre   = tick ? '0 : r.pre + 17'h00001;
    if (tick)
    begin
      next_r.units = r.units + 6'h01;
    end
    unique case (r.state)
      WWS_POR:
      begin
        // Clears are not examined here at all
        if (done(r.units, POR_UNITS, tick))
        begin
          next_r.state = WWS_CLOSED;
          next_r.units = '0;
        end
      end
      WWS_CLOSED:
      begin
        if (clr_edge)
        begin
          next_r.state = WWS_PULSE;
          next_r.units = '0;
          next_r.pre   = '0;
        end
        else if (done(r.units, CLOSED_UNITS, tick))
        begin
          next_r.state = WWS_OPEN;
          next_r.units = '0;
        end
      end
      WWS_OPEN:
      begin
        if (clr_edge)
        begin
          next_r.state = WWS_CLOSED;
          next_r.units = '0;
          next_r.pre   = '0;
        end
        else if (done(r.units, OPEN_UNITS, tick))
        begin
          next_r.state = WWS_PULSE;
          next_r.units = '0;
        end
      end
      WWS_PULSE:
      begin
        if (done(r.units, PULSE_UNITS, tick))
        begin
          next_r.state = WWS_CLOSED;
          next_r.units = '0;
        end
      end
    endcase
    // Monitor low overrides the timer and holds the delay at its start
    if (!vin_ok)
    begin
      next_r.state = WWS_POR;
      next_r.units = '0;
      next_r.pre   = '0;
    end
    next_r.drive = (next_r.state == WWS_POR) ||
                   (next_r.state == WWS_PULSE);
    next_r.pin   = 1'b0;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      r <= '{state: WWS_POR, pre: 17'h00000, units: 6'h00,
             clr_q: 1'b1, drive: 1'b1, pin: 1'b0};
    end
    else if (ce_i)
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // Pin
  // ----------------------------------------------------------------------
  // Data is a constant low held in a flop; only the enable toggles
  assign sys_reset_n_o  = r.pin;
  assign sys_reset_oe_o = r.drive;

endmodule // wws_supervisor

// >>> verification/wws_sup_asserts.sv
// Port assertions for the watchdog reset supervisor
`timescale 1ns/100ps
module wws_sup_asserts #(parameter int UNIT_CYC_P = 10)
(
  input wire logic clk_i,          // Clock
  input wire logic arst_n_i,       // Reset
  input wire logic ce_i,           // Enable
  input wire logic vin_above_i,    // Monitor
  input wire logic wd_clear_n_i,   // Clear
  input wire logic sys_reset_n_o,  // Pin data
  input wire logic sys_reset_oe_o  // Pin enable
);
  int   hi_n;
  int   win_n;
  int   low_n;
  logic clr_q;
  // Run lengths, so window edges are judged in whole cycles; they pause
  // with the enable, as the design's own counters do
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      hi_n  <= 0;
      win_n <= 0;
      low_n <= 0;
      clr_q <= 1'b1;
    end
    else if (ce_i)
    begin
      clr_q <= wd_clear_n_i;
      hi_n  <= sys_reset_oe_o ? hi_n + 1 : 0;
      win_n <= sys_reset_oe_o || (clr_q && !wd_clear_n_i) ? 0 : win_n + 1;
      low_n <= vin_above_i ? 0 : low_n + 1;
    end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_clr;
    $fell(wd_clear_n_i) && !sys_reset_oe_o;
  endsequence
  a_pin_low: assert property (sys_reset_n_o == 1'b0)
    else $error("pin data high");
  a_vin_drop: assert property (low_n > 201 |-> sys_reset_oe_o)
    else $error("no reset on low monitor");
  a_pulse_width: assert property ($fell(sys_reset_oe_o) |->
    hi_n == UNIT_CYC_P || hi_n >= 40 * UNIT_CYC_P) else $error("bad pulse");
  a_win_max: assert property (!sys_reset_oe_o |-> win_n < 482)
    else $error("window too long");
  a_por_hold: assert property (hi_n > UNIT_CYC_P + 2 &&
    hi_n < 40 * UNIT_CYC_P - 1 |=> sys_reset_oe_o) else $error("short hold");
  a_early_clr: assert property (s_clr ##0 (win_n < 300) |->
    ##[1:2] sys_reset_oe_o) else $error("early clear kept");
  a_open_clr: assert property (s_clr ##0 (win_n > 340 && win_n < 460 &&
    low_n == 0) |=> !sys_reset_oe_o [*8]) else $error("open clear reset");
  a_start_hold: assert property ($rose(arst_n_i) |-> sys_reset_oe_o [*2])
    else $error("reset released early");
  a_ce_freeze: assert property (!ce_i |=> $stable(sys_reset_oe_o))
    else $error("pin moved while disabled");
endmodule // wws_sup_asserts

// >>> verification/wws_mcu_model.sv
// Microcontroller model that services the watchdog clear
`timescale 1ns/100ps
module wws_mcu_model
(
  input  wire logic        clk_i,        // Clock
  input  wire logic        reset_pin_i,  // Pin level, low holds us
  input  wire logic [15:0] gap_i,        // Cycles to each clear
  output logic             wd_clear_n_o  // Clear output
);
  logic [15:0] cnt = 16'h0000;
  initial wd_clear_n_o = 1'b1;
  // Held in reset no code runs, so the schedule restarts on release
  always @(negedge clk_i)
    cnt <= !reset_pin_i || cnt == gap_i + 16'h0008 ? 16'h0000
                                                   : cnt + 16'h0001;
  // Eight low cycles keep the pulse above the minimum input width
  always @(negedge clk_i)
    wd_clear_n_o <= !(cnt >= gap_i && cnt < gap_i + 16'h0008);
endmodule // wws_mcu_model

// >>> verification/wws_supervisor_tb.sv
// Self-checking bench for the watchdog reset supervisor
`timescale 1ns/100ps
module wws_supervisor_tb;
  import wws_pkg::*;
  localparam int U = 10;
  logic clk_i = 1'b0, arst_n_i = 1'b0, vin = 1'b1, ovr = 1'b0, ovr_v = 1'b1;
  logic ce = 1'b1;
  logic [15:0] gap = 16'hffff;
  logic [31:0] r = 32'h0000002a;
  logic mcu_n, clr_n, pin_d, oe;
  int errors = 0, total_checks = 0, cyc = 0, n;
  assign clr_n = ovr ? ovr_v : mcu_n;
  initial forever #12.5 clk_i = ~clk_i;
  wws_supervisor #(.UNIT_CYC_P(U)) wws_supervisor_inst (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .ce_i(ce), .vin_above_i(vin),
    .wd_clear_n_i(clr_n), .sys_reset_n_o(pin_d), .sys_reset_oe_o(oe));
  wws_mcu_model wws_mcu_model_inst (.clk_i(clk_i), .reset_pin_i(~oe),
    .gap_i(gap), .wd_clear_n_o(mcu_n));
  function automatic int units(logic [UNIT_W-1:0] k);
    return int'(k) * U;
  endfunction
  function automatic int rnd();
    r ^= r << 13;
    r ^= r >> 17;
    r ^= r << 5;
    return int'(r[30:0]);
  endfunction
  task automatic wait_for(input bit clr, input logic v, input int lim);
    n = 0;
    while ((clr ? clr_n : oe) !== v && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= lim)
    begin
      errors++;
      $display("wrong value at %0t ns: wait ran out", $time);
    end
  endtask
  task automatic count_off(input logic v, input int k);
    n = 0;
    repeat (k)
    begin
      @(negedge clk_i);
      n += int'(oe !== v) + int'(pin_d !== 1'b0);
    end
  endtask
  task automatic chk_cyc(input int lo, input int span);
    total_checks++;
    if (n < lo || n > lo + span)
    begin
      errors++;
      $display("wrong value at %0t ns: %0d cycles", $time, n);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc > 30000)
    begin
      errors++;
      end_of_test();
    end
  end
  initial
  begin
    count_off(1'b1, 6);
    chk_cyc(0, 0);
    arst_n_i <= 1'b1;
    wait_for(1'b0, 1'b0, 1000);
    chk_cyc(units(POR_UNITS), 2);
    $display("power-on test done");
    repeat (2)
    begin
      wait_for(1'b0, 1'b1, 1000);
      chk_cyc(units(CLOSED_UNITS + OPEN_UNITS), 0);
      wait_for(1'b0, 1'b0, 100);
      chk_cyc(units(PULSE_UNITS), 0);
    end
    $display("timeout test done");
    gap <= 16'd100;
    wait_for(1'b1, 1'b0, 600);
    wait_for(1'b0, 1'b1, 5);
    // The clear is seen one sample late, after the edge that took it
    chk_cyc(0, 0);
    wait_for(1'b0, 1'b0, 100);
    chk_cyc(units(PULSE_UNITS), 0);
    $display("early clear test done");
    for (int i = 0; i < 6; i++)
    begin
      gap <= 16'(i % 2 ? 10 + rnd() % 280 : 330 + rnd() % 100);
      repeat (1000) @(negedge clk_i);
      count_off(1'b0, 1000);
      if (i % 2)
        chk_cyc(1, 999);
      else
        chk_cyc(0, 0);
    end
    $display("random service test done");
    // Steady open-window service, so no watchdog pulse hides in the dip
    gap <= 16'd380;
    repeat (1000) @(negedge clk_i);
    vin <= 1'b0;
    count_off(1'b0, 150 + rnd() % 40);
    vin <= 1'b1;
    chk_cyc(0, 0);
    @(negedge clk_i);
    vin <= 1'b0;
    wait_for(1'b0, 1'b1, 400);
    chk_cyc(200, 2);
    $display("monitor test done");
    // Clear toggles while held, which must not shorten the hold
    ovr <= 1'b1;
    repeat (100) @(negedge clk_i);
    vin <= 1'b1;
    n = 0;
    while (oe !== 1'b0 && n < 600)
    begin
      @(negedge clk_i);
      n++;
      ovr_v <= n[3];
    end
    chk_cyc(units(POR_UNITS), 2);
    $display("hold test done");
    // A frozen stretch must lengthen the window by exactly its length
    ce <= 1'b0;
    count_off(1'b0, 50);
    chk_cyc(0, 0);
    ce <= 1'b1;
    wait_for(1'b0, 1'b1, 600);
    chk_cyc(units(CLOSED_UNITS + OPEN_UNITS), 0);
    $display("enable test done");
    end_of_test();
  end
endmodule // wws_supervisor_tb
bind wws_supervisor wws_sup_asserts #(.UNIT_CYC_P(UNIT_CYC_P))
  wws_sup_asserts_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
  .vin_above_i(vin_above_i), .wd_clear_n_i(wd_clear_n_i),
  .sys_reset_n_o(sys_reset_n_o), .sys_reset_oe_o(sys_reset_oe_o));
